// >>> src/timer8_pkg.sv
`default_nettype none
package timer8_pkg;
    localparam int unsigned CNT_W = 8;
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX = 8'hff;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic [2:0] WS_NORMAL = 3'h0;
    localparam logic [2:0] WS_PC_FF = 3'h1;
    localparam logic [2:0] WS_CTC = 3'h2;
    localparam logic [2:0] WS_FAST_FF = 3'h3;
    localparam logic [2:0] WS_PC_OCA = 3'h5;
    localparam logic [2:0] WS_FAST_OCA = 3'h7;
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    // APB register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_COUNT = 12'h004;
    localparam logic [11:0] OFS_CMP_A = 12'h008;
    localparam logic [11:0] OFS_CMP_B = 12'h00c;
    localparam logic [11:0] OFS_FLAGS = 12'h010;
    // Control field positions
    localparam int unsigned CTRL_WS_LSB = 0;
    localparam int unsigned CTRL_ACTA_LSB = 4;
    localparam int unsigned CTRL_ACTB_LSB = 6;
    localparam int unsigned CTRL_PRE_LSB = 8;
    localparam int unsigned CTRL_DIRA_BIT = 12;
    localparam int unsigned CTRL_DIRB_BIT = 13;
    localparam int unsigned FLG_OVF_BIT = 0;
    localparam int unsigned FLG_CMPA_BIT = 1;
    localparam int unsigned FLG_CMPB_BIT = 2;
    // Prescaler select codes
    localparam logic [2:0] PRE_STOP = 3'h0;
    localparam logic [2:0] PRE_1 = 3'h1;
    localparam logic [2:0] PRE_8 = 3'h2;
    localparam logic [2:0] PRE_64 = 3'h3;
    localparam logic [2:0] PRE_256 = 3'h4;
    localparam logic [2:0] PRE_1024 = 3'h5;
    localparam int unsigned PRE_W = 10;
    typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
    typedef struct packed {
        logic dir_b;
        logic dir_a;
        logic [2:0] pre;
        logic [1:0] act_b;
        logic [1:0] act_a;
        logic [2:0] ws;
    } ctrl_t;
    typedef struct packed {
        logic cmp_b;
        logic cmp_a;
        logic ovf;
    } flags_t;
endpackage
`default_nettype wire

// >>> src/timer8_prescaler.sv
`default_nettype none
module timer8_prescaler
    import timer8_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] sel,
    output logic tick
);
    import timer8_pkg::*;
    logic [PRE_W-1:0] div;
    // Free-running divider; a tap pulses once per period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end
    always_comb begin
        case (sel)
            PRE_1: tick = 1'b1;
            PRE_8: tick = (div[2:0] == 3'h7);
            PRE_64: tick = (div[5:0] == 6'h3f);
            PRE_256: tick = (div[7:0] == 8'hff);
            PRE_1024: tick = (div == 10'h3ff);
            default: tick = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// >>> src/timer8_waveform_modes.sv
// Notes on behaviour
// - Mode 2 clears count on compare A match; compare A is top.
// - Clear-on-match mode writes compare A directly, no buffer.
// - Compare A written below count misses match; count wraps via 0xff.
// - Clear-on-match mode sets compare A flag one timer cycle after count matches top.
// - Action 1 in clear-on-match toggles output A each match.
// - Output A reaches pin only when its direction bit says output.
// - Timer enable is I/O clock divided by 1, 8, 64, 256 or 1024.
// - Clear-on-match sets overflow flag as count rolls from max to zero.
// - Fast PWM is mode 3 or 7; top 0xff or compare A.
// - Fast PWM counts up to top then clears next timer cycle.
// - Fast PWM action 2 clears on match, sets at bottom; 3 opposite.
// - Fast PWM sets overflow flag when counter reaches top.
// - PWM action 1 toggles output A only with select msb; never B.
// - Fast PWM compare at bottom spikes; at max gives constant level.
// - Fast PWM compare writes pass through double buffer.
// - Phase-correct is mode 1 or 5; up then down; top 0xff or A.
// - Phase-correct holds top for exactly one timer cycle.
// - Phase-correct non-inverting clears on up match, sets on down.
// - Phase-correct sets overflow flag when counter reaches bottom.
// - Phase-correct compare at bottom low, at max high; inverted opposite.
// - Phase-correct forces down-match level at bottom unless compare is bottom.
// - A match sets its compare flag one timer cycle later.
// - PWM buffered compares load only at top, never at bottom.
// - Reset forces waveform state registers to zero.
// - Action 0 leaves waveform untouched and disconnects the pin.
`default_nettype none
module timer8_waveform_modes
    import timer8_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_a_data,
    input wire logic port_b_data,
    output logic pin_a,
    output logic pin_a_oe,
    output logic pin_b,
    output logic pin_b_oe,
    output logic overflow_flag,
    output logic compare_a_flag,
    output logic compare_b_flag
);
    import timer8_pkg::*;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    ctrl_t ctrl;
    logic [7:0] count_value;
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic [7:0] cmp_a_buf;
    logic [7:0] cmp_b_buf;
    flags_t flags;
    logic wave_out_a;
    logic wave_out_b;
    dir_t dir;
    logic tick;
    logic wr;
    logic rd;
    logic block_match;

    function automatic logic is_pwm(input logic [2:0] ws);
        is_pwm = ws[0];
    endfunction

    function automatic logic is_pc(input logic [2:0] ws);
        is_pc = (ws == WS_PC_FF) || (ws == WS_PC_OCA);
    endfunction

    function automatic logic known_addr(input logic [11:0] a);
        if (a == OFS_CTRL) begin
            known_addr = 1'b1;
        end else if (a == OFS_COUNT || a == OFS_CMP_A) begin
            known_addr = 1'b1;
        end else if (a == OFS_CMP_B || a == OFS_FLAGS) begin
            known_addr = 1'b1;
        end else begin
            known_addr = 1'b0;
        end
    endfunction

    assign wr = psel && penable && pwrite && pready;
    assign rd = psel && !penable && !pwrite;

    // Ready a cycle after setup: no wait state, access lasts two cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known_addr(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd) begin
            if (paddr == OFS_CTRL) begin
                prdata <= {18'h0, ctrl.dir_b, ctrl.dir_a, 1'b0, ctrl.pre,
                           ctrl.act_b, ctrl.act_a, 1'b0, ctrl.ws};
            end else if (paddr == OFS_COUNT) begin
                prdata <= {24'h0, count_value};
            end else if (paddr == OFS_CMP_A) begin
                prdata <= {24'h0, is_pwm(ctrl.ws) ? cmp_a_buf
                                                  : compare_a_value};
            end else if (paddr == OFS_CMP_B) begin
                prdata <= {24'h0, is_pwm(ctrl.ws) ? cmp_b_buf
                                                  : compare_b_value};
            end else if (paddr == OFS_FLAGS) begin
                prdata <= {29'h0, flags};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
        end else if (wr && paddr == OFS_CTRL) begin
            ctrl.ws <= pwdata[CTRL_WS_LSB +: 3];
            ctrl.act_a <= pwdata[CTRL_ACTA_LSB +: 2];
            ctrl.act_b <= pwdata[CTRL_ACTB_LSB +: 2];
            ctrl.pre <= pwdata[CTRL_PRE_LSB +: 3];
            ctrl.dir_a <= pwdata[CTRL_DIRA_BIT];
            ctrl.dir_b <= pwdata[CTRL_DIRB_BIT];
        end
    end

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    timer8_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .sel(ctrl.pre),
        .tick(tick)
    );

    // ****************************************************************
    // Counter
    // ****************************************************************
    logic [7:0] top;
    logic at_top;
    logic at_bottom;
    logic match_a;
    logic match_b;
    logic cnt_wr;
    assign top = (ctrl.ws[2] || ctrl.ws == WS_CTC) ? compare_a_value
                                                   : MAX;
    assign at_top = (count_value == top);
    assign at_bottom = (count_value == BOTTOM);
    assign cnt_wr = wr && paddr == OFS_COUNT;
    assign match_a = (count_value == compare_a_value) && !block_match;
    assign match_b = (count_value == compare_b_value) && !block_match;

    // Count write masks matches for the next timer cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_match <= 1'b0;
        end else if (cnt_wr) begin
            block_match <= 1'b1;
        end else if (tick) begin
            block_match <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= RST_COUNT;
            dir <= DIR_UP;
        end else if (cnt_wr) begin
            count_value <= pwdata[7:0];
        end else if (tick) begin
            if (is_pc(ctrl.ws)) begin
                if (dir == DIR_UP && at_top) begin
                    dir <= DIR_DOWN;
                    count_value <= count_value - 8'h01;
                end else if (dir == DIR_DOWN && at_bottom) begin
                    dir <= DIR_UP;
                    count_value <= count_value + 8'h01;
                end else if (dir == DIR_UP) begin
                    count_value <= count_value + 8'h01;
                end else begin
                    count_value <= count_value - 8'h01;
                end
            end else if (ctrl.ws == WS_CTC && match_a) begin
                count_value <= BOTTOM;
            end else if (is_pwm(ctrl.ws) && at_top) begin
                count_value <= BOTTOM;
            end else begin
                dir <= DIR_UP;
                count_value <= count_value + 8'h01;
            end
        end
    end

    // ****************************************************************
    // Compare registers
    // ****************************************************************
    logic load_pt;
    assign load_pt = tick && (is_pc(ctrl.ws) ? (dir == DIR_UP && at_top)
                                             : at_top);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_a_buf <= RST_COMPARE;
            cmp_b_buf <= RST_COMPARE;
        end else begin
            if (wr && paddr == OFS_CMP_A) begin
                cmp_a_buf <= pwdata[7:0];
            end
            if (wr && paddr == OFS_CMP_B) begin
                cmp_b_buf <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_a_value <= RST_COMPARE;
            compare_b_value <= RST_COMPARE;
        end else if (is_pwm(ctrl.ws)) begin
            if (load_pt) begin
                compare_a_value <= cmp_a_buf;
                compare_b_value <= cmp_b_buf;
            end
        end else begin
            if (wr && paddr == OFS_CMP_A) begin
                compare_a_value <= pwdata[7:0];
            end
            if (wr && paddr == OFS_CMP_B) begin
                compare_b_value <= pwdata[7:0];
            end
        end
    end

    // ****************************************************************
    // Flags
    // ****************************************************************
    logic ovf_evt;
    logic ovf_clr;
    logic [2:0] clr;
    logic pend_a;
    logic pend_b;
    assign clr = (wr && paddr == OFS_FLAGS) ? pwdata[2:0] : 3'h0;
    always_comb begin
        if (is_pc(ctrl.ws)) begin
            ovf_evt = tick && dir == DIR_DOWN && count_value == 8'h01;
        end else if (is_pwm(ctrl.ws)) begin
            ovf_evt = tick && count_value == top - 8'h01;
        end else begin
            ovf_evt = tick && count_value == MAX;
        end
    end

    // Match latched now, flag raised on the next timer cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_a <= 1'b0;
            pend_b <= 1'b0;
        end else if (tick) begin
            pend_a <= match_a;
            pend_b <= match_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
        end else begin
            flags.ovf <= ovf_evt | (flags.ovf & ~clr[FLG_OVF_BIT]);
            flags.cmp_a <= (tick & pend_a)
                         | (flags.cmp_a & ~clr[FLG_CMPA_BIT]);
            flags.cmp_b <= (tick & pend_b)
                         | (flags.cmp_b & ~clr[FLG_CMPB_BIT]);
        end
    end

    // ****************************************************************
    // Waveform generator
    // ****************************************************************
    function automatic logic next_wave(input logic cur,
                                       input logic [1:0] act,
                                       input logic chan_a,
                                       input logic m,
                                       input logic [7:0] cmp);
        logic v;
        v = cur;
        if (act == ACT_OFF) begin
            v = cur;
        end else if (act == ACT_TOGGLE) begin
            if (m && (!is_pwm(ctrl.ws) || (chan_a && ctrl.ws[2]))) begin
                v = !cur;
            end
        end else if (!is_pwm(ctrl.ws)) begin
            if (m) begin
                v = (act == ACT_SET);
            end
        end else if (!is_pc(ctrl.ws)) begin
            if (at_top) begin
                v = (act == ACT_CLEAR);
            end else if (m && cmp != top) begin
                v = (act == ACT_SET);
            end
            if (m && at_top && cmp == BOTTOM) begin
                v = (act == ACT_SET);
            end
        end else begin
            if (dir == DIR_DOWN && at_bottom) begin
                v = (act == ACT_CLEAR) ? (cmp == BOTTOM) ? 1'b0 : 1'b1
                                       : (cmp == BOTTOM);
            end else if (m && cmp == top) begin
                v = (act == ACT_CLEAR);
            end else if (m) begin
                v = (dir == DIR_UP) ? (act == ACT_SET)
                                    : (act == ACT_CLEAR);
            end
        end
        next_wave = v;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_out_a <= 1'b0;
            wave_out_b <= 1'b0;
        end else if (tick) begin
            wave_out_a <= next_wave(wave_out_a, ctrl.act_a, 1'b1,
                                    match_a, compare_a_value);
            wave_out_b <= next_wave(wave_out_b, ctrl.act_b, 1'b0,
                                    match_b, compare_b_value);
        end
    end

    // ****************************************************************
    // Pin mux
    // ****************************************************************
    // Toggle action in a PWM mode leaves the pin to the port, except A
    // with the select msb set
    function automatic logic joined(input logic [1:0] act,
                                    input logic chan_a);
        joined = (act != ACT_OFF)
               && !(act == ACT_TOGGLE && is_pwm(ctrl.ws)
                    && !(chan_a && ctrl.ws[2]));
    endfunction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a <= 1'b0;
            pin_b <= 1'b0;
            pin_a_oe <= 1'b0;
            pin_b_oe <= 1'b0;
            overflow_flag <= 1'b0;
            compare_a_flag <= 1'b0;
            compare_b_flag <= 1'b0;
        end else begin
            pin_a <= joined(ctrl.act_a, 1'b1) ? wave_out_a : port_a_data;
            pin_b <= joined(ctrl.act_b, 1'b0) ? wave_out_b : port_b_data;
            pin_a_oe <= ctrl.dir_a;
            pin_b_oe <= ctrl.dir_b;
            overflow_flag <= flags.ovf;
            compare_a_flag <= flags.cmp_a;
            compare_b_flag <= flags.cmp_b;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_ctc_hit;
        tick && ctrl.ws == WS_CTC && match_a && !cnt_wr;
    endsequence

    chk_ctc_clear: assert property (@(posedge pclk) disable iff (!presetn)
        s_ctc_hit |=> count_value == BOTTOM)
        else $error("count not cleared on match");
    // Cycles since a compare A match while its flag is still low
    logic [10:0] flag_wait;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_wait <= 11'h000;
        end else if (flags.cmp_a) begin
            flag_wait <= 11'h000;
        end else if (tick && match_a) begin
            flag_wait <= 11'h001;
        end else if (flag_wait != 11'h000 && flag_wait != 11'h7ff) begin
            flag_wait <= flag_wait + 11'h001;
        end
    end

    chk_flag_delay: assert property (@(posedge pclk) disable iff (!presetn)
        flag_wait <= 11'h401)
        else $error("compare flag not raised");
    chk_pc_dir: assert property (@(posedge pclk) disable iff (!presetn)
        tick && is_pc(ctrl.ws) && dir == DIR_UP && at_top && !cnt_wr
        |=> dir == DIR_DOWN)
        else $error("direction not reversed at top");
    chk_pin_oe: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 pin_a_oe == $past(ctrl.dir_a))
        else $error("pin enable mismatch");
    chk_ovf_set: assert property (@(posedge pclk) disable iff (!presetn)
        ovf_evt |=> flags.ovf)
        else $error("overflow flag lost");
    chk_fast_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        tick && ctrl.ws == WS_FAST_FF && count_value == MAX && !cnt_wr
        |=> count_value == BOTTOM)
        else $error("fast pwm did not wrap");
    chk_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
        !tick && !cnt_wr |=> $stable(count_value))
        else $error("count moved without enable");
    chk_off_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl.act_b == ACT_OFF |=> $stable(wave_out_b))
        else $error("wave moved while off");
    chk_ctc_direct: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == OFS_CMP_A && !is_pwm(ctrl.ws)
        |=> compare_a_value == $past(pwdata[7:0]))
        else $error("direct compare write lost");
endmodule
`default_nettype wire

// >>> sim/pin_load.sv
`default_nettype none
module pin_load (
    input wire logic pin,
    input wire logic oe,
    output logic pad
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pad is pulled up by the external load
    assign pad = oe ? pin : 1'b1;
endmodule
`default_nettype wire

// >>> sim/timer8_waveform_modes_tb.sv
`default_nettype none
module timer8_waveform_modes_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import timer8_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic port_a_data = 1'b0;
    logic port_b_data = 1'b0;
    logic pin_a, pin_a_oe, pin_b, pin_b_oe, pad_a, pad_b;
    logic overflow_flag, compare_a_flag, compare_b_flag;
    logic [31:0] rdata;
    logic rerr;
    int checks = 0;
    int miscompares = 0;
    int ha, hb, ea;
    always #2 pclk = ~pclk;
    timer8_waveform_modes dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_a_data(port_a_data), .port_b_data(port_b_data),
        .pin_a(pin_a), .pin_a_oe(pin_a_oe), .pin_b(pin_b),
        .pin_b_oe(pin_b_oe), .overflow_flag(overflow_flag),
        .compare_a_flag(compare_a_flag), .compare_b_flag(compare_b_flag));
    pin_load load_a (.pin(pin_a), .oe(pin_a_oe), .pad(pad_a));
    pin_load load_b (.pin(pin_b), .oe(pin_b_oe), .pad(pad_b));
    // ****************
    // Shared tasks
    // ****************
    task check(input string nm, input logic [31:0] seen,
               input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) miscompares++;
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] ctrl(logic [2:0] ws, logic [1:0] act,
                                         logic [2:0] pre, logic dir);
        return (32'(ws) << CTRL_WS_LSB) | (32'(act) << CTRL_ACTA_LSB)
            | (32'(act) << CTRL_ACTB_LSB) | (32'(pre) << CTRL_PRE_LSB)
            | (32'(dir) << CTRL_DIRA_BIT) | (32'(dir) << CTRL_DIRB_BIT);
    endfunction
    // Stops the timer, clears flags and count, then restarts at full rate
    task cfg(input logic [2:0] ws, input logic [1:0] act,
             input logic [7:0] ca, input logic [7:0] cb);
        apb(1'b1, OFS_CTRL, ctrl(ws, act, PRE_STOP, 1'b1));
        apb(1'b1, OFS_FLAGS, 32'h7);
        apb(1'b1, OFS_COUNT, 32'h0);
        apb(1'b1, OFS_CMP_A, {24'h0, ca});
        apb(1'b1, OFS_CMP_B, {24'h0, cb});
        apb(1'b1, OFS_CTRL, ctrl(ws, act, PRE_1, 1'b1));
    endtask
    task measure(input int n);
        logic p;
        ha = 0;
        hb = 0;
        ea = 0;
        @(negedge pclk);
        p = pad_a;
        repeat (n) begin
            @(negedge pclk);
            ha += int'(pad_a);
            hb += int'(pad_b);
            ea += int'(pad_a !== p);
            p = pad_a;
        end
    endtask
    // ****************
    // Scenarios
    // ****************
    task t_reset;
        check("pin_a", {pin_a, pin_a_oe}, 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        check("ctrl", rdata, 32'h0);
        apb(1'b0, OFS_FLAGS, 32'h0);
        check("flags", rdata, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        check("unmapped", {rdata[30:0], rerr}, 32'h1);
    endtask
    task t_ctc;
        cfg(WS_CTC, ACT_TOGGLE, 8'h00, 8'h00);
        // Count write blocks the first match, so the count wraps first
        repeat (300) @(posedge pclk);
        measure(64);
        check("ctc edges top0", ea, 64);
        cfg(WS_CTC, ACT_TOGGLE, 8'h03, 8'h01);
        repeat (8) @(posedge pclk);
        measure(64);
        check("ctc edges top3", ea, 16);
        check("cmp flag", compare_a_flag, 1'b1);
        check("cmp b flag", compare_b_flag, 1'b1);
        check("ovf flag", overflow_flag, 1'b0);
    endtask
    task t_miss;
        cfg(WS_CTC, ACT_TOGGLE, 8'h05, 8'h01);
        apb(1'b1, OFS_CTRL, ctrl(WS_CTC, ACT_TOGGLE, PRE_STOP, 1'b1));
        apb(1'b1, OFS_FLAGS, 32'h7);
        apb(1'b1, OFS_COUNT, 32'h0a);
        apb(1'b0, OFS_COUNT, 32'h0);
        apb(1'b0, OFS_COUNT, 32'h0);
        check("stopped count", rdata, 32'h0a);
        apb(1'b1, OFS_CTRL, ctrl(WS_CTC, ACT_TOGGLE, PRE_1, 1'b1));
        repeat (20) @(posedge pclk);
        apb(1'b0, OFS_COUNT, 32'h0);
        check("missed match", rdata[7:0] > 8'h05, 1'b1);
        repeat (300) @(posedge pclk);
        check("wrap ovf", overflow_flag, 1'b1);
        apb(1'b0, OFS_COUNT, 32'h0);
        check("after wrap", rdata[7:0] <= 8'h05, 1'b1);
    endtask
    task t_pwm(input logic [2:0] ws, input int per, input int mul);
        logic [7:0] c;
        for (int a = 2; a <= 3; a++) begin
            for (int k = 0; k < 3; k++) begin
                c = (k == 0) ? 8'h00 : (k == 1) ? 8'h3f : 8'hff;
                cfg(ws, 2'(a), c, c >> 1);
                repeat (2 * per) @(posedge pclk);
                measure(per);
                check("high a", ha, (a == 2) ? mul * c + (2 - mul)
                    : per - mul * c - (2 - mul));
                check("high b", hb, (a == 2) ? mul * (c >> 1) + (2 - mul)
                    : per - mul * (c >> 1) - (2 - mul));
                check("ovf", overflow_flag, 1'b1);
            end
        end
    endtask
    task t_toggle;
        port_a_data <= 1'b1;
        cfg(WS_FAST_OCA, ACT_TOGGLE, 8'h00, 8'h00);
        repeat (600) @(posedge pclk);
        measure(64);
        check("toggle msb", ea, 64);
        cfg(WS_FAST_FF, ACT_TOGGLE, 8'h00, 8'h00);
        measure(64);
        check("toggle off", ha, 64);
        cfg(WS_CTC, ACT_OFF, 8'h00, 8'h00);
        port_a_data <= 1'b0;
        measure(64);
        check("port data", ha, 0);
        apb(1'b1, OFS_CTRL, ctrl(WS_CTC, ACT_TOGGLE, PRE_1, 1'b0));
        repeat (4) @(posedge pclk);
        check("oe off", {pin_a_oe, pad_a}, 32'h1);
    endtask
    initial begin
        #160000;
        miscompares++;
        conclude;
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_ctc;
        t_miss;
        t_pwm(WS_FAST_FF, 256, 1);
        t_pwm(WS_PC_FF, 510, 2);
        t_toggle;
        conclude;
    end
endmodule
`default_nettype wire
